// file: rtl/mbc_checker.sv
/*
  mbc_checker: slave request checker for a serial register protocol.
  takes whole frames from a same-clock uart, checks them, applies writes to
  the parameter store, and emits replies or exceptions byte by byte.
  assumes: the store answers i_par_rsp combinationally for o_par_req.addr.
*/
// What this block does
// - 32-bit write to 16-bit parameter accepted only within its normal range.
// - 16-bit write to 32-bit parameter is sign-extended, range -32768..+32767.
// - address bits 15..14 nonzero ask for 32-bit access; both clear means 16-bit.
// - a function, address or count error in a valid non-broadcast request gets an exception reply.
// - incomplete or bad-crc frame gets no reply; master times out.
// - oversized write frame is discarded whole, no exception.
// - exception is node, function code with bit 7, code, crc low, high.
// - code 1 for unknown function, code 2 for bad address or count.
// - block write goes in order, stops at first bad value, count reports it.
// - combined read/write gives no sign of an out-of-range write.
// - frames end in crc-16 x16+x15+x2+1, low byte first.
// - crc covers every preceding byte including address and function.
// - buffer size sets the largest block one request may move.
// - address bits 15..14 select int16, int32, float32 or reserved.
// - a 32-bit parameter is two registers, high word first.
// - 32-bit access needs an even register count, else code 2.
`timescale 1ns/1ps
module mbc_checker (
  // clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_reset_n,
  // configuration
  input  wire logic [7:0]               i_node_addr,
  // receive byte stream
  input  wire logic                     i_rx_valid,
  input  wire logic [7:0]               i_rx_data,
  input  wire logic                     i_rx_end,
  // transmit byte stream
  input  wire logic                     i_tx_ready,
  output logic                          o_tx_valid,
  output logic      [7:0]               o_tx_data,
  // parameter store
  input  wire mbc_pkg::mbc_par_rsp_type i_par_rsp,
  output mbc_pkg::mbc_par_req_type      o_par_req
);
  import mbc_pkg::*;

  typedef enum logic [2:0] {S_RX, S_CHECK, S_WADR, S_WCHK, S_RADR, S_RGET, S_TX} mbc_state_type;

  mbc_state_type state_q;
  logic          rst_q1, rst_n;
  logic [7:0]    buf_q [64];
  logic [6:0]    cnt_q, ptr_q, tx_len_q, tx_idx_q;
  logic          ovf_q, bcast_q, rw_q;
  logic [1:0]    typ_q;
  logic [13:0]   paddr_q;
  logic [15:0]   elem_q, succ_q;
  logic [15:0]   succ_d;
  logic [15:0]   rx_crc, tx_crc;
  logic [15:0]   h_addr, h_qty, w_addr, w_qty;
  logic [16:0]   need;
  logic [7:0]    exc;
  logic          frame_ok, is32;
  logic [31:0]   wval, rval;
  logic          wr_ok, wr_done, rd_done, tx_hs;
  logic [6:0]    step;

  // reset released through two flops so removal is clean
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  function automatic logic [7:0] chk(input logic [15:0] a, input logic [15:0] q,
                                     input logic [15:0] lim, input logic rd);
    logic [15:0] n;
    n = (a[15:14] == TYP_INT16) ? q : (q >> 1);
    if (a[15:14] == TYP_RSVD) return EXC_ADDR;
    if (a[15:14] != TYP_INT16 && q[0]) return EXC_ADDR;
    if (q == 16'h0000 || q > lim) return EXC_ADDR;
    if (rd && a[15:14] == TYP_FLOAT && !FLOAT_SUPPORTED) return EXC_ADDR;
    if ({3'b000, a[13:0]} + {1'b0, n} > PAR_COUNT) return EXC_ADDR;
    return EXC_NONE;
  endfunction : chk

  assign h_addr   = {buf_q[B_ADDR], buf_q[B_ADDR + 6'h01]};
  assign h_qty    = {buf_q[B_QTY], buf_q[B_QTY + 6'h01]};
  assign w_addr   = {buf_q[B_WADDR], buf_q[B_WADDR + 6'h01]};
  assign w_qty    = {buf_q[B_WQTY], buf_q[B_WQTY + 6'h01]};
  assign frame_ok = !ovf_q && cnt_q >= MIN_FRAME && rx_crc == CRC_RESIDUE &&
                    (buf_q[B_NODE] == i_node_addr || buf_q[B_NODE] == BCAST_ADDR);

  always_comb begin
    need = {10'h000, MIN_FRAME};
    exc  = EXC_FUNC;
    unique case (buf_q[B_FC])
      FC_READ: begin
        need = {10'h000, RD_FRAME};
        exc  = chk(h_addr, h_qty, MAX_RD_REGS, 1'b1);
      end
      FC_WRITE: begin
        need = {10'h000, WR_HDR} + {h_qty, 1'b0};
        exc  = chk(h_addr, h_qty, MAX_WR_REGS, 1'b0);
      end
      FC_RDWR: begin
        need = {10'h000, RW_HDR} + {w_qty, 1'b0};
        exc  = chk(h_addr, h_qty, MAX_RW_REGS, 1'b1) | chk(w_addr, w_qty, MAX_RW_REGS, 1'b0);
      end
      default: ;
    endcase
  end

  // element value: 32-bit high word first, 16-bit sign-extended
  assign is32 = typ_q != TYP_INT16;
  assign wval = is32 ? {buf_q[ptr_q[5:0]], buf_q[ptr_q[5:0] + 6'h01],
                        buf_q[ptr_q[5:0] + 6'h02], buf_q[ptr_q[5:0] + 6'h03]}
                     : {{16{buf_q[ptr_q[5:0]][7]}}, buf_q[ptr_q[5:0]], buf_q[ptr_q[5:0] + 6'h01]};
  assign rval = i_par_rsp.is32 ? i_par_rsp.rdata : {{16{i_par_rsp.rdata[15]}}, i_par_rsp.rdata[15:0]};
  assign step = is32 ? 7'h04 : 7'h02;
  // float selection counts as over range when unsupported
  assign wr_ok   = !(typ_q == TYP_FLOAT && !FLOAT_SUPPORTED) &&
                   $signed(wval) >= $signed(i_par_rsp.min) && $signed(wval) <= $signed(i_par_rsp.max);
  assign wr_done = state_q == S_WCHK && (!wr_ok || elem_q == 16'h0001);
  assign rd_done = state_q == S_RGET && elem_q == 16'h0001;
  // count including the element checked this cycle, so a clean last write is reported
  assign succ_d  = succ_q + (wr_ok ? (is32 ? 16'h0002 : 16'h0001) : 16'h0000);
  assign tx_hs   = o_tx_valid && i_tx_ready;

  // sequencer
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_RX;
      typ_q   <= TYP_INT16;
      paddr_q <= 14'h0000;
      elem_q  <= 16'h0000;
      ptr_q   <= 7'h00;
      succ_q  <= 16'h0000;
      bcast_q <= 1'b0;
      rw_q    <= 1'b0;
    end else begin
      unique case (state_q)
        S_RX: if (i_rx_end) state_q <= S_CHECK;
        S_CHECK: begin
          bcast_q <= buf_q[B_NODE] == BCAST_ADDR;
          rw_q    <= buf_q[B_FC] == FC_RDWR;
          succ_q  <= 16'h0000;
          if (!frame_ok || (exc == EXC_NONE && {10'h000, cnt_q} < need)) begin
            state_q <= S_RX;
          end else if (exc != EXC_NONE) begin
            state_q <= (buf_q[B_NODE] == BCAST_ADDR) ? S_RX : S_TX;
          end else if (buf_q[B_FC] == FC_READ) begin
            {typ_q, paddr_q} <= h_addr;
            elem_q  <= is32_of(h_addr) ? h_qty >> 1 : h_qty;
            ptr_q   <= P_RDATA;
            state_q <= S_RADR;
          end else begin
            {typ_q, paddr_q} <= (buf_q[B_FC] == FC_RDWR) ? w_addr : h_addr;
            elem_q  <= (buf_q[B_FC] == FC_RDWR) ? (is32_of(w_addr) ? w_qty >> 1 : w_qty)
                                                 : (is32_of(h_addr) ? h_qty >> 1 : h_qty);
            ptr_q   <= (buf_q[B_FC] == FC_RDWR) ? P_WR23 : P_WR16;
            state_q <= S_WADR;
          end
        end
        S_WADR: state_q <= S_WCHK;
        S_WCHK: begin
          if (wr_ok) begin
            succ_q  <= succ_q + (is32 ? 16'h0002 : 16'h0001);
            paddr_q <= paddr_q + 14'h0001;
            elem_q  <= elem_q - 16'h0001;
            ptr_q   <= ptr_q + step;
          end
          if (wr_done && rw_q) begin
            {typ_q, paddr_q} <= h_addr;
            elem_q  <= is32_of(h_addr) ? h_qty >> 1 : h_qty;
            ptr_q   <= P_RDATA;
            state_q <= S_RADR;
          end else if (wr_done) begin
            state_q <= bcast_q ? S_RX : S_TX;
          end else begin
            state_q <= S_WADR;
          end
        end
        S_RADR: state_q <= S_RGET;
        S_RGET: begin
          paddr_q <= paddr_q + 14'h0001;
          elem_q  <= elem_q - 16'h0001;
          ptr_q   <= ptr_q + step;
          if (rd_done) state_q <= bcast_q ? S_RX : S_TX;
          else state_q <= S_RADR;
        end
        S_TX: if (tx_hs && tx_idx_q == tx_len_q + 7'h01) state_q <= S_RX;
      endcase
    end
  end

  function automatic logic is32_of(input logic [15:0] a);
    return a[15:14] != TYP_INT16;
  endfunction : is32_of

  // frame buffer: request bytes in, reply built in place
  always_ff @(posedge i_clk) begin
    if (state_q == S_RX && i_rx_valid && cnt_q < BUF_BYTES) begin
      buf_q[cnt_q[5:0]] <= i_rx_data;
    end else if (state_q == S_CHECK && frame_ok && exc != EXC_NONE) begin
      buf_q[B_FC]   <= buf_q[B_FC] | FC_EXC_BIT;
      buf_q[B_CODE] <= exc;
    end else if (wr_done && !rw_q) begin
      buf_q[B_QTY]         <= succ_d[15:8];
      buf_q[B_QTY + 6'h01] <= succ_d[7:0];
    end else if (state_q == S_RGET) begin
      if (is32) begin
        buf_q[ptr_q[5:0]]         <= rval[31:24];
        buf_q[ptr_q[5:0] + 6'h01] <= rval[23:16];
        buf_q[ptr_q[5:0] + 6'h02] <= rval[15:8];
        buf_q[ptr_q[5:0] + 6'h03] <= rval[7:0];
      end else begin
        buf_q[ptr_q[5:0]]         <= rval[15:8];
        buf_q[ptr_q[5:0] + 6'h01] <= rval[7:0];
      end
      if (rd_done) buf_q[B_CODE] <= {1'b0, ptr_q + step - P_RDATA};
    end
  end

  // receive count; overflow marks the frame for silent discard
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 7'h00;
      ovf_q <= 1'b0;
    end else if (state_q == S_CHECK) begin
      cnt_q <= 7'h00;
      ovf_q <= 1'b0;
    end else if (state_q == S_RX && i_rx_valid) begin
      if (cnt_q < BUF_BYTES) cnt_q <= cnt_q + 7'h01;
      else ovf_q <= 1'b1;
    end
  end

  // store request; a failed check never writes
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_par_req <= '0;
    end else begin
      o_par_req.wr <= state_q == S_WCHK && wr_ok;
      if (state_q == S_WADR || state_q == S_RADR) o_par_req.addr <= paddr_q;
      if (state_q == S_WCHK) o_par_req.data <= wval;
    end
  end

  // transmit: one idle cycle after each byte lets the crc settle
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_tx_valid <= 1'b0;
      o_tx_data  <= 8'h00;
      tx_idx_q   <= 7'h00;
      tx_len_q   <= 7'h00;
    end else if (state_q != S_TX) begin
      o_tx_valid <= 1'b0;
      tx_idx_q   <= 7'h00;
      if (state_q == S_CHECK) tx_len_q <= LEN_EXC;
      else if (wr_done) tx_len_q <= LEN_WR;
      else if (rd_done) tx_len_q <= ptr_q + step;
    end else if (tx_hs) begin
      o_tx_valid <= 1'b0;
      tx_idx_q   <= tx_idx_q + 7'h01;
    end else if (!o_tx_valid) begin
      o_tx_valid <= 1'b1;
      if (tx_idx_q < tx_len_q) o_tx_data <= buf_q[tx_idx_q[5:0]];
      else if (tx_idx_q == tx_len_q) o_tx_data <= tx_crc[7:0];
      else o_tx_data <= tx_crc[15:8];
    end
  end

  mbc_crc16 u_rx_crc (
    .i_clk     (i_clk),
    .i_reset_n (rst_n),
    .i_clear   (state_q == S_CHECK),
    .i_en      (state_q == S_RX && i_rx_valid),
    .i_byte    (i_rx_data),
    .o_crc     (rx_crc)
  );

  mbc_crc16 u_tx_crc (
    .i_clk     (i_clk),
    .i_reset_n (rst_n),
    .i_clear   (state_q == S_CHECK),
    .i_en      (tx_hs && tx_idx_q < tx_len_q),
    .i_byte    (o_tx_data),
    .o_crc     (tx_crc)
  );

  bad_frame_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    state_q == S_CHECK && !frame_ok |=> state_q == S_RX ##1 !o_tx_valid)
    else $error("bad frame was not dropped");
  overflow_drop_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    state_q == S_CHECK && ovf_q |=> state_q == S_RX && !o_par_req.wr)
    else $error("oversized frame not discarded");
  exc_fcode_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    state_q == S_CHECK && frame_ok && exc != EXC_NONE && buf_q[B_NODE] != BCAST_ADDR
    |=> buf_q[B_FC][7] && buf_q[B_CODE] == $past(exc) && tx_len_q == LEN_EXC)
    else $error("exception frame malformed");
  bad_func_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    state_q == S_CHECK && frame_ok && buf_q[B_FC] != FC_READ && buf_q[B_FC] != FC_WRITE
    && buf_q[B_FC] != FC_RDWR && buf_q[B_NODE] != BCAST_ADDR |=> buf_q[B_CODE] == EXC_FUNC)
    else $error("unsupported function not code 1");
  sign_ext_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_par_req.wr && $past(typ_q) == TYP_INT16 |-> o_par_req.data[31:16] == {16{o_par_req.data[15]}})
    else $error("16-bit write not sign extended");
  range_wr_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_par_req.wr |-> $signed(o_par_req.data) >= $signed($past(i_par_rsp.min))
    && $signed(o_par_req.data) <= $signed($past(i_par_rsp.max)))
    else $error("out-of-range value written");
  stop_block_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    state_q == S_WCHK && !wr_ok |=> !o_par_req.wr ##1 !o_par_req.wr ##1 !o_par_req.wr)
    else $error("block write continued after bad value");
  bcast_quiet_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    bcast_q && state_q != S_CHECK |-> !o_tx_valid)
    else $error("broadcast answered");
  crc_low_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_tx_valid && state_q == S_TX && tx_idx_q == tx_len_q |-> o_tx_data == tx_crc[7:0])
    else $error("crc low byte not sent first");
endmodule : mbc_checker

// file: rtl/mbc_pkg.sv
/*
  mbc_pkg: constants, field positions and carrier types shared by the
  request checker and its crc unit.
  assumes: one 40 MHz clock domain, byte stream from a same-clock uart.
*/
package mbc_pkg;
  // frame buffer, sized by the device's maximum buffer size
  localparam logic [6:0]  BUF_BYTES   = 7'h40;
  localparam logic [6:0]  MIN_FRAME   = 7'h04;
  localparam logic [6:0]  RD_FRAME    = 7'h08;
  localparam logic [6:0]  WR_HDR      = 7'h09;
  localparam logic [6:0]  RW_HDR      = 7'h0D;
  localparam logic [15:0] MAX_RD_REGS = 16'h001D;
  localparam logic [15:0] MAX_WR_REGS = 16'h001B;
  localparam logic [15:0] MAX_RW_REGS = 16'h0019;
  // byte positions in request and reply
  localparam logic [5:0]  B_NODE  = 6'h00;
  localparam logic [5:0]  B_FC    = 6'h01;
  localparam logic [5:0]  B_CODE  = 6'h02;
  localparam logic [5:0]  B_ADDR  = 6'h02;
  localparam logic [5:0]  B_QTY   = 6'h04;
  localparam logic [5:0]  B_WADDR = 6'h06;
  localparam logic [5:0]  B_WQTY  = 6'h08;
  localparam logic [6:0]  P_WR16  = 7'h07;
  localparam logic [6:0]  P_WR23  = 7'h0B;
  localparam logic [6:0]  P_RDATA = 7'h03;
  localparam logic [6:0]  LEN_EXC = 7'h03;
  localparam logic [6:0]  LEN_WR  = 7'h06;
  // function and exception codes
  localparam logic [7:0]  FC_READ    = 8'h03;
  localparam logic [7:0]  FC_WRITE   = 8'h10;
  localparam logic [7:0]  FC_RDWR    = 8'h17;
  localparam logic [7:0]  FC_EXC_BIT = 8'h80;
  localparam logic [7:0]  EXC_NONE   = 8'h00;
  localparam logic [7:0]  EXC_FUNC   = 8'h01;
  localparam logic [7:0]  EXC_ADDR   = 8'h02;
  localparam logic [7:0]  BCAST_ADDR = 8'h00;
  // type field in address bits 15..14
  localparam logic [1:0]  TYP_INT16 = 2'h0;
  localparam logic [1:0]  TYP_INT32 = 2'h1;
  localparam logic [1:0]  TYP_FLOAT = 2'h2;
  localparam logic [1:0]  TYP_RSVD  = 2'h3;
  localparam logic        FLOAT_SUPPORTED = 1'b0;
  localparam logic [16:0] PAR_COUNT = 17'h00BB8;
  // crc-16, reflected form of x16+x15+x2+1
  localparam logic [15:0] CRC_INIT    = 16'hFFFF;
  localparam logic [15:0] CRC_POLY    = 16'hA001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;

  typedef struct packed {
    logic        wr;
    logic [13:0] addr;
    logic [31:0] data;
  } mbc_par_req_type;

  typedef struct packed {
    logic        is32;
    logic [31:0] min;
    logic [31:0] max;
    logic [31:0] rdata;
  } mbc_par_rsp_type;
endpackage : mbc_pkg

// file: rtl/mbc_crc16.sv
/*
  mbc_crc16: byte-serial crc-16 accumulator, one byte per clock.
  assumes: reset already synchronised by the instantiating module.
*/
`timescale 1ns/1ps
module mbc_crc16 (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // control and data
  input  wire logic        i_clear,
  input  wire logic        i_en,
  input  wire logic [7:0]  i_byte,
  // running value
  output logic      [15:0] o_crc
);
  import mbc_pkg::*;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_crc <= CRC_INIT;
    end else if (i_clear) begin
      o_crc <= CRC_INIT;
    end else if (i_en) begin
      o_crc <= crc_step(o_crc, i_byte);
    end
  end
endmodule : mbc_crc16

// file: verif/mbc_store_model.sv
/*
  mbc_store_model: behavioural parameter store that sits behind the checker.
  assumes: 16 stored words indexed by addr[3:0], odd addresses are 32-bit.
*/
`timescale 1ns/1ps
module mbc_store_model (
  // clock
  input  wire logic                     i_clk,
  // store port
  input  wire mbc_pkg::mbc_par_req_type i_par_req,
  output mbc_pkg::mbc_par_rsp_type      o_par_rsp
);
  import mbc_pkg::*;
  logic [31:0] mem_q [16];
  logic        is32;
  // aliasing addresses keeps the model tiny; the bench shadow aliases the same way
  assign is32            = i_par_req.addr[0];
  assign o_par_rsp.is32  = is32;
  assign o_par_rsp.min   = is32 ? 32'hFFFE7960 : 32'hFFFFD8F0;
  assign o_par_rsp.max   = is32 ? 32'h000186A0 : 32'h00002710;
  // upper half of a 16-bit word is junk, so the checker must extend it itself
  assign o_par_rsp.rdata = is32 ? mem_q[i_par_req.addr[3:0]] :
                           {~mem_q[i_par_req.addr[3:0]][31:16], mem_q[i_par_req.addr[3:0]][15:0]};
  initial begin
    for (int k = 0; k < 16; k++) begin
      mem_q[k] = k * 32'h111;
    end
  end
  always @(posedge i_clk) begin
    if (i_par_req.wr) begin
      mem_q[i_par_req.addr[3:0]] <= is32 ? i_par_req.data : {{16{i_par_req.data[15]}}, i_par_req.data[15:0]};
    end
  end
endmodule : mbc_store_model

// file: verif/tb.sv
/*
  tb: self-checking bench for the request checker, acting as bus master.
  assumes: store model answers combinationally, one 40 MHz clock.
*/
`timescale 1ns/1ps
module tb;
  import mbc_pkg::*;
  typedef logic [7:0] mbc_bytes_type [$];
  localparam int         LIMIT = 60000;
  localparam logic [7:0] NODE  = 8'h11;
  logic            clk      = 1'b0;
  logic            rst_n    = 1'b0;
  logic            rx_valid = 1'b0;
  logic [7:0]      rx_data  = 8'h00;
  logic            rx_end   = 1'b0;
  logic            tx_ready = 1'b1;
  logic            tx_valid;
  logic [7:0]      tx_data;
  mbc_par_req_type par_req;
  mbc_par_rsp_type par_rsp;
  logic [31:0]     sh [16];
  mbc_bytes_type   got;
  mbc_bytes_type   none;
  int              bad_count       = 0;
  int              samples_checked = 0;
  int              cycles          = 0;

  always #12.5 clk = ~clk;

  mbc_checker mbc_checker_i (
    .i_clk       (clk),
    .i_reset_n   (rst_n),
    .i_node_addr (NODE),
    .i_rx_valid  (rx_valid),
    .i_rx_data   (rx_data),
    .i_rx_end    (rx_end),
    .i_tx_ready  (tx_ready),
    .o_tx_valid  (tx_valid),
    .o_tx_data   (tx_data),
    .i_par_rsp   (par_rsp),
    .o_par_req   (par_req)
  );

  mbc_store_model mbc_store_model_i (
    .i_clk     (clk),
    .i_par_req (par_req),
    .o_par_rsp (par_rsp)
  );

  // master takes reply bytes, stalling at random but always listening
  always @(posedge clk) begin
    cycles   <= cycles + 1;
    tx_ready <= ($urandom_range(0, 3) != 0);
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
    if (cycles == LIMIT) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk

  function automatic mbc_bytes_type seal(mbc_bytes_type q);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    return q;
  endfunction : seal

  function automatic mbc_bytes_type rd_req(logic [7:0] nd, logic [15:0] a, int n);
    return seal('{nd, FC_READ, a[15:8], a[7:0], 8'h00, 8'(n)});
  endfunction : rd_req

  function automatic mbc_bytes_type wr_req(logic [7:0] nd, logic [15:0] a, logic [15:0] w[$]);
    mbc_bytes_type q;
    q = '{nd, FC_WRITE, a[15:8], a[7:0], 8'h00, 8'(w.size()), 8'(2 * w.size())};
    foreach (w[i]) begin
      q.push_back(w[i][15:8]);
      q.push_back(w[i][7:0]);
    end
    return seal(q);
  endfunction : wr_req

  function automatic mbc_bytes_type wr_rep(logic [15:0] a, int n);
    return seal('{NODE, FC_WRITE, a[15:8], a[7:0], 8'h00, 8'(n)});
  endfunction : wr_rep

  function automatic mbc_bytes_type exc(logic [7:0] fc, logic [7:0] code);
    return seal('{NODE, fc | 8'h80, code});
  endfunction : exc

  // 32-bit access: high word then low word of each parameter
  function automatic mbc_bytes_type rd_exp(logic [7:0] fc, logic [15:0] a, int n);
    mbc_bytes_type q;
    logic [13:0]   p;
    logic [31:0]   v;
    q = '{NODE, fc, 8'(2 * n)};
    for (int k = 0; k < n; k++) begin
      p = a[13:0] + 14'(a[14] ? k / 2 : k);
      v = sh[p[3:0]];
      if (a[14] && k % 2 == 0) begin
        v = v >> 16;
      end
      q.push_back(v[15:8]);
      q.push_back(v[7:0]);
    end
    return seal(q);
  endfunction : rd_exp

  task automatic xfer(mbc_bytes_type req, mbc_bytes_type exp);
    int idle;
    got = {};
    foreach (req[i]) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= req[i];
      @(posedge clk);
      rx_valid <= 1'b0;
    end
    @(posedge clk);
    rx_end <= 1'b1;
    @(posedge clk);
    rx_end <= 1'b0;
    idle = 0;
    // silence ends the wait, also the slow turnaround after a broadcast
    while (idle < 80) begin
      @(posedge clk);
      idle = tx_valid ? 0 : idle + 1;
    end
    chk(32'(got.size()), 32'(exp.size()));
    foreach (exp[i]) begin
      if (i < got.size()) begin
        chk(got[i], exp[i]);
      end
    end
  endtask : xfer

  initial begin
    logic [15:0]   w [$];
    logic [15:0]   ea [7];
    int            eq [7];
    logic [7:0]    uf [3];
    int            cp [3];
    logic [15:0]   a;
    logic [15:0]   v;
    mbc_bytes_type q;
    void'($urandom(35));
    for (int k = 0; k < 16; k++) begin
      sh[k] = k * 32'h111;
    end
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    uf = '{8'h01, 8'h05, 8'h2B};
    foreach (uf[i]) begin
      xfer(seal('{NODE, uf[i], 8'h00, 8'h00, 8'h00, 8'h01}), exc(uf[i], EXC_FUNC));
    end
    ea = '{16'h0BB8, 16'h0BB7, 16'h4001, 16'h8000, 16'hC000, 16'h0000, 16'h0000};
    eq = '{1, 2, 1, 2, 2, 30, 0};
    for (int i = 0; i < 7; i++) begin
      xfer(rd_req(NODE, ea[i], eq[i]), exc(FC_READ, EXC_ADDR));
    end
    xfer(rd_req(NODE, 16'h0000, 29), rd_exp(FC_READ, 16'h0000, 29));
    w = '{16'h0100, 16'hABCD, 16'h7FFF, 16'h0005};
    xfer(wr_req(NODE, 16'h0002, w), wr_rep(16'h0002, 2));
    sh[2] = 32'h00000100;
    sh[3] = 32'hFFFFABCD;
    w = '{16'h0000, 16'h0123, 16'h0001, 16'h86A0, 16'h0001, 16'h0005};
    xfer(wr_req(NODE, 16'h4006, w), wr_rep(16'h4006, 4));
    sh[6] = 32'h00000123;
    sh[7] = 32'h000186A0;
    xfer(rd_req(NODE, 16'h4002, 14), rd_exp(FC_READ, 16'h4002, 14));
    w = '{16'hFF9C};
    xfer(wr_req(BCAST_ADDR, 16'h000A, w), none);
    sh[10] = 32'hFFFFFF9C;
    xfer(rd_req(NODE, 16'h400A, 2), rd_exp(FC_READ, 16'h400A, 2));
    cp = '{0, 1, 7};
    foreach (cp[i]) begin
      q = rd_req(NODE, 16'h0001, 1);
      q[cp[i]] ^= 8'h04;
      xfer(q, none);
    end
    xfer(rd_req(8'h12, 16'h0001, 1), none);
    q = '{NODE, FC_READ, 8'h00};
    xfer(q, none);
    w = {};
    repeat (28) w.push_back(16'h0077);
    xfer(wr_req(NODE, 16'h000E, w), none);
    xfer(rd_req(NODE, 16'h000E, 1), rd_exp(FC_READ, 16'h000E, 1));
    void'(w.pop_back());
    xfer(wr_req(NODE, 16'h000E, w), wr_rep(16'h000E, 27));
    for (int k = 0; k < 27; k++) begin
      sh[(14 + k) % 16] = 32'h00000077;
    end
    q = '{NODE, FC_RDWR, 8'h00, 8'h0C, 8'h00, 8'h01, 8'h00, 8'h0C, 8'h00, 8'h01, 8'h02, 8'h7F, 8'hFF};
    xfer(seal(q), rd_exp(FC_RDWR, 16'h000C, 1));
    repeat (20) begin
      a = 16'($urandom_range(0, 2999));
      v = 16'(int'($urandom_range(0, 20000)) - 10000);
      w = '{v};
      xfer(wr_req(NODE, a, w), wr_rep(a, 1));
      sh[a[3:0]] = {{16{v[15]}}, v};
      if ($urandom_range(0, 1) == 1) begin
        xfer(rd_req(NODE, a | 16'h4000, 2), rd_exp(FC_READ, a | 16'h4000, 2));
      end else begin
        xfer(rd_req(NODE, a, 1), rd_exp(FC_READ, a, 1));
      end
    end
    stop_test();
  end
endmodule : tb
